// ==== mrp_pkg.sv ====
// constants for the measurement result post-processing block
package mrp_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CFG1 = 8'h04;
	localparam logic [7:0] OFS_GAIN_A = 8'h10;
	localparam logic [7:0] OFS_GAIN_B = 8'h14;
	localparam logic [7:0] OFS_GAIN_C = 8'h18;
	localparam logic [7:0] OFS_GAIN_D = 8'h1C;
	localparam logic [7:0] OFS_VRP = 8'h20;
	localparam logic [7:0] OFS_SUPPLY = 8'h24;
	localparam logic [7:0] OFS_CFG12 = 8'h30;
	localparam logic [7:0] OFS_USRPRG = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	// field positions
	localparam int VRP_EN_BIT = 11;
	localparam int NOISE_EN_BIT = 7;
	localparam int SUP_EN_BIT = 8;
	localparam int USR_FLAG_BIT = 0;
	// reset values
	localparam logic [23:0] GAIN_ONE = 24'h100000;
	localparam logic [7:0] SUP_FACTOR_RST = 8'hF7;
	// fixed-point fractions, half-bridge count and result base address
	localparam int RP_FRAC = 20;
	localparam int GAIN_FRAC = 20;
	localparam int SUP_SHIFT = 21;
	localparam int NUM_HB = 4;
	localparam logic [7:0] RESULT_BASE = 8'hF4;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_LOAD = 4'h1,
		ST_VRP = 4'h2,
		ST_GAIN = 4'h3,
		ST_SUP = 4'h4,
		ST_DIVW = 4'h5,
		ST_WRITE = 4'h6,
		ST_USR = 4'h7
	} mrp_state_t;
endpackage : mrp_pkg

// ==== mrp_div.sv ====
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module mrp_div #(
	parameter int NW = 53,
	parameter int DW = 34
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request
	input wire logic start,
	input wire logic [NW-1:0] num,
	input wire logic [DW-1:0] den,
	// answer
	output logic done,
	output logic [NW-1:0] quo
);
	localparam int CW = $clog2(NW + 1);
	logic [DW:0] rem_q;
	logic [CW-1:0] cnt_q;
	logic [DW:0] sh;
	logic [DW:0] dif;

	// shifted remainder and trial subtraction
	always_comb begin
		sh = {rem_q[DW-1:0], quo[NW-1]};
		dif = sh - {1'b0, den};
	end

	// iteration control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rem_q <= '0;
			quo <= '0;
			cnt_q <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem_q <= '0;
				quo <= num;
				cnt_q <= CW'(NW);
			end else if (cnt_q != '0) begin
				if (sh >= {1'b0, den}) begin
					rem_q <= dif;
					quo <= {quo[NW-2:0], 1'b1};
				end else begin
					rem_q <= sh;
					quo <= {quo[NW-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
				done <= (cnt_q == CW'(1));
			end
		end
	end
endmodule : mrp_div
`default_nettype wire

// ==== mrp_top.sv ====
// result post-processing datapath with noise-suppression port control
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module mrp_top
	import mrp_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter side
	input wire logic meas_done,
	input wire logic [95:0] half_bridge_result,
	input wire logic [23:0] measured_supply_voltage,
	input wire logic meas_active,
	input wire logic [1:0] meas_port,
	// result ram write port and program start
	output logic ram_we,
	output logic [7:0] ram_addr,
	output logic [23:0] ram_wdata,
	output logic user_prog_start,
	output logic busy,
	// grounding transistor gates, one per port
	output logic [3:0] port_ground_en
);
	logic [31:0] cfg1_q;
	logic [23:0] gain_q [NUM_HB];
	logic signed [23:0] vrp_q;
	logic sup_en_q;
	logic signed [7:0] sup_factor_q;
	logic noise_en_q;
	logic usr_flag_q;
	logic [7:0] run_cnt_q;
	mrp_state_t state_q;
	logic [1:0] hb_q;
	logic signed [31:0] acc_q;
	logic [95:0] raw_q;
	logic [23:0] ub_q;
	logic acc_neg_q;
	logic div_start_q;
	logic div_done;
	logic [52:0] div_quo;
	logic signed [55:0] vrp_prod;
	logic signed [56:0] gain_prod;
	logic signed [33:0] sup_den;
	logic [31:0] acc_abs;
	logic [31:0] rd_data;
	logic rd_hit;
	logic wr_go;
	logic [23:0] sat_val;

	// write taken when both channels valid and no answer pending
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid
		& ~s_axi_awready;

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// write channel handshake and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready <= wr_go;
			s_axi_bvalid <= s_axi_awready | (s_axi_bvalid & ~s_axi_bready);
			if (wr_go) begin
				case (s_axi_awaddr)
					OFS_CFG1, OFS_GAIN_A, OFS_GAIN_B, OFS_GAIN_C,
					OFS_GAIN_D, OFS_VRP, OFS_SUPPLY, OFS_CFG12,
					OFS_USRPRG, OFS_STATUS: s_axi_bresp <= RESP_OKAY;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg1_q <= '0;
			for (int i = 0; i < NUM_HB; i++) begin
				gain_q[i] <= GAIN_ONE;
			end
			vrp_q <= '0;
			sup_en_q <= 1'b0;
			sup_factor_q <= SUP_FACTOR_RST;
			noise_en_q <= 1'b0;
			usr_flag_q <= 1'b0;
		end else if (wr_go) begin
			case (s_axi_awaddr)
				OFS_CFG1: cfg1_q <= merge(cfg1_q, s_axi_wdata, s_axi_wstrb);
				OFS_GAIN_A: gain_q[0] <= 24'(merge({8'h00, gain_q[0]},
					s_axi_wdata, s_axi_wstrb));
				OFS_GAIN_B: gain_q[1] <= 24'(merge({8'h00, gain_q[1]},
					s_axi_wdata, s_axi_wstrb));
				OFS_GAIN_C: gain_q[2] <= 24'(merge({8'h00, gain_q[2]},
					s_axi_wdata, s_axi_wstrb));
				OFS_GAIN_D: gain_q[3] <= 24'(merge({8'h00, gain_q[3]},
					s_axi_wdata, s_axi_wstrb));
				OFS_VRP: vrp_q <= 24'(merge({8'h00, vrp_q},
					s_axi_wdata, s_axi_wstrb));
				OFS_SUPPLY: begin
					if (s_axi_wstrb[0]) sup_factor_q <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1]) sup_en_q <= s_axi_wdata[SUP_EN_BIT];
				end
				OFS_CFG12: if (s_axi_wstrb[0]) begin
					noise_en_q <= s_axi_wdata[NOISE_EN_BIT];
				end
				OFS_USRPRG: if (s_axi_wstrb[0]) begin
					usr_flag_q <= s_axi_wdata[USR_FLAG_BIT];
				end
				default: ;
			endcase
		end
	end

	// read decode
	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			OFS_CFG1: rd_data = cfg1_q;
			OFS_GAIN_A: rd_data = {8'h00, gain_q[0]};
			OFS_GAIN_B: rd_data = {8'h00, gain_q[1]};
			OFS_GAIN_C: rd_data = {8'h00, gain_q[2]};
			OFS_GAIN_D: rd_data = {8'h00, gain_q[3]};
			OFS_VRP: rd_data = {8'h00, vrp_q};
			OFS_SUPPLY: rd_data = {23'h0, sup_en_q, sup_factor_q};
			OFS_CFG12: rd_data = {24'h0, noise_en_q, 7'h00};
			OFS_USRPRG: rd_data = {31'h0, usr_flag_q};
			OFS_STATUS: rd_data = {16'h0, run_cnt_q, 7'h00, busy};
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid
				& ~s_axi_arready;
			if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// correction arithmetic
	always_comb begin
		vrp_prod = acc_q * vrp_q;
		gain_prod = acc_q * $signed({1'b0, gain_q[hb_q]});
		// divisor is 2^21 + supply * factor
		sup_den = (34'sd1 <<< SUP_SHIFT)
			+ $signed({10'h000, ub_q}) * sup_factor_q;
		acc_abs = acc_q[31] ? 32'(-acc_q) : 32'(acc_q);
		if (acc_q > 32'sh007FFFFF) begin
			sat_val = 24'h7FFFFF;
		end else if (acc_q < -32'sh00800000) begin
			sat_val = 24'h800000;
		end else begin
			sat_val = acc_q[23:0];
		end
	end

	mrp_div #(.NW(53), .DW(34)) u_div (.aclk(aclk), .aresetn(aresetn),
		.start(div_start_q), .num({21'h0, acc_abs} << SUP_SHIFT),
		.den(34'(sup_den)), .done(div_done), .quo(div_quo));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			hb_q <= '0;
			acc_q <= '0;
			raw_q <= '0;
			ub_q <= '0;
			acc_neg_q <= 1'b0;
			div_start_q <= 1'b0;
			ram_we <= 1'b0;
			ram_addr <= '0;
			ram_wdata <= '0;
			user_prog_start <= 1'b0;
			busy <= 1'b0;
			run_cnt_q <= '0;
		end else begin
			div_start_q <= 1'b0;
			ram_we <= 1'b0;
			user_prog_start <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// a measurement end starts a run only in ST_IDLE; an end flag during a run is ignored
					if (meas_done) begin
						raw_q <= half_bridge_result;
						ub_q <= measured_supply_voltage;
						hb_q <= '0;
						busy <= 1'b1;
						state_q <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					acc_q <= 32'($signed(raw_q[24*hb_q +: 24]));
					state_q <= ST_VRP;
				end
				ST_VRP: begin
					if (cfg1_q[VRP_EN_BIT]) begin
						acc_q <= acc_q + 32'(vrp_prod >>> RP_FRAC);
					end
					state_q <= ST_GAIN;
				end
				ST_GAIN: begin
					acc_q <= 32'(gain_prod >>> GAIN_FRAC);
					state_q <= ST_SUP;
				end
				ST_SUP: begin
					if (sup_en_q && sup_den > 0) begin
						acc_neg_q <= acc_q[31];
						div_start_q <= 1'b1;
						state_q <= ST_DIVW;
					end else begin
						state_q <= ST_WRITE;
					end
				end
				ST_DIVW: begin
					if (div_done) begin
						acc_q <= acc_neg_q ? -$signed(div_quo[31:0])
							: $signed(div_quo[31:0]);
						state_q <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					ram_we <= 1'b1;
					ram_addr <= RESULT_BASE + 8'(hb_q);
					ram_wdata <= sat_val;
					hb_q <= hb_q + 1'b1;
					state_q <= (hb_q == 2'(NUM_HB - 1)) ? ST_USR : ST_LOAD;
				end
				ST_USR: begin
					// program start only with flag set
					user_prog_start <= usr_flag_q;
					run_cnt_q <= run_cnt_q + 1'b1;
					busy <= 1'b0;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// grounding transistors for unmeasured ports
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_ground_en <= '0;
		end else if (noise_en_q && meas_active) begin
			// all but the measured port grounded
			port_ground_en <= ~(4'h1 << meas_port);
		end else begin
			port_ground_en <= '0;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_corr;
		state_q == ST_LOAD ##1 state_q == ST_VRP ##1 state_q == ST_GAIN;
	endsequence

	a_corr_order: assert property (
		state_q == ST_LOAD |-> s_corr)
		else $error("correction steps out of order");
	a_vrp_off: assert property (
		state_q == ST_VRP && !cfg1_q[VRP_EN_BIT] |=> $stable(acc_q))
		else $error("virtual resistor applied while disabled");
	a_gain_apply: assert property (
		state_q == ST_GAIN |=> acc_q == 32'($past(gain_prod) >>> GAIN_FRAC))
		else $error("half-bridge gain not applied");
	a_sup_off: assert property (
		state_q == ST_SUP && !sup_en_q |=> state_q == ST_WRITE)
		else $error("supply correction while disabled");
	a_sup_div: assert property (
		state_q == ST_SUP && sup_en_q && sup_den > 0 |=> div_start_q
		##[1:60] div_done)
		else $error("supply division not finished");
	a_run_store: assert property (
		state_q == ST_IDLE && meas_done |-> ##[5:400] ram_we)
		else $error("no result stored after measurement");
	a_usr_flag: assert property (
		user_prog_start |-> usr_flag_q && $past(state_q) == ST_USR)
		else $error("user program started without flag");
	a_write_state: assert property (
		ram_we |-> $past(state_q) == ST_WRITE)
		else $error("result stored outside write step");
	a_noise_off: assert property (
		!noise_en_q |=> port_ground_en == 4'h0)
		else $error("grounding while noise suppression off");
	a_noise_port: assert property (
		noise_en_q && meas_active |=>
		port_ground_en == ~(4'h1 << $past(meas_port)))
		else $error("wrong port grounding pattern");
	a_gain_width: assert property (
		s_axi_rvalid && s_axi_arready && $past(s_axi_araddr) == OFS_GAIN_A
		|-> s_axi_rdata[31:24] == 8'h00)
		else $error("gain register wider than 24 bits");
endmodule : mrp_top
`default_nettype wire

// ==== mrp_conv_model.sv ====
// converter-side model: measurement timing, port stepping, result hand-off
`timescale 1ns/10ps
`default_nettype none
module mrp_conv_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control
	input wire logic go,
	input wire logic [7:0] lag,
	input wire logic [23:0] x,
	input wire logic [23:0] ub,
	// converter outputs
	output logic meas_done,
	output var logic [95:0] half_bridge_result,
	output var logic [23:0] measured_supply_voltage,
	output logic meas_active,
	output logic [1:0] meas_port
);
	logic [8:0] cnt_q;
	// measure lag+1 cycles stepping the port, then flag the end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 9'h000;
			meas_done <= 1'h0;
			meas_active <= 1'h0;
			meas_port <= 2'h0;
		end else begin
			meas_done <= (cnt_q == 9'h001);
			if (go) begin
				cnt_q <= {1'h0, lag} + 9'h001;
				meas_active <= 1'h1;
			end else if (cnt_q != 9'h000) begin
				cnt_q <= cnt_q - 9'h001;
				meas_port <= meas_port + 2'h1;
				meas_active <= (cnt_q != 9'h001);
			end
		end
	end
	// results only valid with the end flag; otherwise a changed pattern
	assign half_bridge_result = meas_done ? {4{x}} : ~{4{x}};
	assign measured_supply_voltage = meas_done ? ub : ~ub;
endmodule : mrp_conv_model
`default_nettype wire

// ==== tb_measurement_result_postprocess.sv ====
// self-checking bench for the result post-processing block
`timescale 1ns/10ps
`default_nettype none
module tb_measurement_result_postprocess import mrp_pkg::*;;
	typedef struct {
		logic [23:0] x;
		logic [31:0] c1;
		logic [31:0] vrp;
		logic [31:0] sup;
		logic [23:0] ub;
		logic [31:0] u;
		logic [23:0] e;
	} mrp_row_t;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic meas_done, meas_active, ram_we, user_prog_start, busy;
	logic [95:0] half_bridge_result;
	logic [23:0] measured_supply_voltage, ram_wdata;
	logic [1:0] meas_port;
	logic [7:0] ram_addr;
	logic [3:0] port_ground_en;
	logic go = 1'h0;
	logic [7:0] lag = 8'h00;
	logic [23:0] mx = 24'h0, mub = 24'h0;
	int fail_count = 0, total_checks = 0, cyc = 0, got_n = 0, ups = 0;
	logic [7:0] got_a [8];
	logic [23:0] got_d [8];
	logic chk_g = 1'h0, nz = 1'h0, p_act = 1'h0;
	logic [1:0] p_port = 2'h0;
	mrp_row_t rows [6];

	// 50 ns clock
	always #25 aclk = ~aclk;

	mrp_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas_done,
		.half_bridge_result, .measured_supply_voltage, .meas_active,
		.meas_port, .ram_we, .ram_addr, .ram_wdata, .user_prog_start,
		.busy, .port_ground_en);
	mrp_conv_model cvm (.aclk, .aresetn, .go, .lag, .x(mx), .ub(mub),
		.meas_done, .half_bridge_result, .measured_supply_voltage,
		.meas_active, .meas_port);

	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [23:0] sat(input int v);
		if (v > 32'sh007FFFFF)
			return 24'h7FFFFF;
		if (v < -32'sh00800000)
			return 24'h800000;
		return v[23:0];
	endfunction : sat

	// bus write: hold each channel until taken, bready until bvalid
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		chk(32'(s_axi_bresp), 32'(r));
	endtask : axw

	// bus read: rready held until rvalid
	task automatic axr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, d);
		chk(32'(s_axi_rresp), 32'(r));
	endtask : axr

	// one measurement; dbl pulses go again while busy, so a second end flag arrives during the run
	task automatic run(input logic [23:0] x, input logic [23:0] u_b,
		input logic [7:0] l, input logic dbl);
		@(posedge aclk);
		mx <= x;
		mub <= u_b;
		lag <= l;
		go <= 1'h1;
		got_n = 0;
		ups = 0;
		@(posedge aclk);
		go <= 1'h0;
		while (!busy) @(posedge aclk);
		if (dbl) begin
			go <= 1'h1;
			@(posedge aclk);
			go <= 1'h0;
		end
		while (busy) @(posedge aclk);
		@(posedge aclk);
	endtask : run

	// capture ram writes, program starts, grounding, and cut hangs
	always @(posedge aclk) begin
		cyc++;
		if (ram_we) begin
			got_a[got_n[2:0]] = ram_addr;
			got_d[got_n[2:0]] = ram_wdata;
			got_n++;
		end
		if (user_prog_start) ups++;
		if (chk_g)
			chk(32'(port_ground_en), (nz && p_act) ?
				{28'h0, ~(4'h1 << p_port)} : 32'h0);
		p_act = meas_active;
		p_port = meas_port;
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	// rows: x, cfg1, rp value, supply reg, supply voltage, flag, result
	initial begin
		rows[0] = '{24'h000100, 32'h0, 32'h80000, 32'hF7, 24'h0, 32'h1,
			24'h000100};
		rows[1] = '{24'h000100, 32'h800, 32'h80000, 32'h0, 24'h0, 32'h0,
			24'h000180};
		rows[2] = '{24'hFFFF00, 32'h800, 32'hF80000, 32'h0, 24'h0, 32'h1,
			24'hFFFF80};
		rows[3] = '{24'h000100, 32'h0, 32'h0, 32'h101, 24'h200000, 32'h0,
			24'h000080};
		rows[4] = '{24'h400000, 32'h0, 32'h0, 32'h0, 24'h0, 32'h0,
			24'h400000};
		rows[5] = '{24'h000100, 32'h0, 32'h0, 32'h1F7, 24'h0, 32'h1,
			24'h000100};
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		axr(OFS_GAIN_A, 32'h00100000, RESP_OKAY);
		axr(OFS_SUPPLY, 32'h000000F7, RESP_OKAY);
		axr(8'h3C, 32'h0, RESP_SLVERR);
		axw(8'h40, 32'h1, RESP_SLVERR);
		s_axi_wstrb <= 4'h1;
		axw(OFS_GAIN_B, 32'h00ABCDEF, RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		axw(OFS_SUPPLY, 32'h00000100, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axr(OFS_GAIN_B, 32'h001000EF, RESP_OKAY);
		axr(OFS_SUPPLY, 32'h000001F7, RESP_OKAY);
		for (int n = 0; n < 4; n++)
			axw(OFS_GAIN_A + 8'(4 * n), 32'h00100000 * (n + 1), RESP_OKAY);
		axr(OFS_GAIN_D, 32'h00400000, RESP_OKAY);
		chk_g = 1'h1;
		$display("registers done");
		for (int i = 0; i < 6; i++) begin
			axw(OFS_CFG1, rows[i].c1, RESP_OKAY);
			axw(OFS_VRP, rows[i].vrp, RESP_OKAY);
			axw(OFS_SUPPLY, rows[i].sup, RESP_OKAY);
			axw(OFS_USRPRG, rows[i].u, RESP_OKAY);
			run(rows[i].x, rows[i].ub, 8'(i), 1'h0);
			chk(32'(got_n), 32'h4);
			for (int n = 0; n < 4; n++) begin
				chk(32'(got_a[n]), 32'(RESULT_BASE + 8'(n)));
				chk(32'(got_d[n]),
					32'(sat($signed(rows[i].e) * (n + 1))));
			end
			chk(32'(ups), rows[i].u);
			$display("row %0d done", i);
		end
		chk_g = 1'h0;
		axw(OFS_CFG12, 32'h80, RESP_OKAY);
		nz = 1'h1;
		chk_g = 1'h1;
		run(24'h000100, 24'h0, 8'h09, 1'h1);
		chk(32'(got_n), 32'h4);
		chk_g = 1'h0;
		$display("grounding done");
		@(posedge aclk);
		go <= 1'h1;
		@(posedge aclk);
		go <= 1'h0;
		while (!busy) @(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		chk(32'({busy, ram_we, user_prog_start, port_ground_en}), 32'h0);
		aresetn <= 1'h1;
		nz = 1'h0;
		axr(OFS_GAIN_C, 32'h00100000, RESP_OKAY);
		axr(OFS_CFG12, 32'h0, RESP_OKAY);
		$display("reset done");
		wrap_up();
	end
endmodule : tb_measurement_result_postprocess
`default_nettype wire
